/* tb_top.sv */
// Self-checking bench for the write permission guard.
// Assumes the bus master model and the port checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic		clock = 1'b0;
	logic		srst = 1'b1;
	logic		cyc = 1'b0;
	logic		stb = 1'b0;
	logic		we = 1'b0;
	logic [7:0]	adr = 8'h00;
	logic [3:0]	sel = 4'hF;
	logic [31:0]	datW = 32'h0;
	logic [31:0]	datR;
	logic		ack;
	logic		scl;
	logic		sda;
	logic		wp = 1'b0;
	logic		grant;
	logic [17:0]	req;
	logic		active;
	logic		busy;
	int		badCount = 0;
	int		numChecks = 0;
	always #25 clock = ~clock;
	wpg_bus_master i_bus (.clock(clock), .scl(scl), .sda(sda));
	wpg_write_permission_guard #(.NV_WRITE_CYCLES(50)) i_dut
		(.clock(clock), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
		.sclPin(scl), .sdaPin(sda), .wpPin(wp), .wrGrant(grant),
		.wrReq(req), .deviceActive(active), .nvBusy(busy));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp)
		begin
			badCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic g);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		r = datR;
		g = grant;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk({31'h0, ack}, 32'h1);
	endtask : wb
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic g;
		wb(1'b0, a, 32'h0, r, g);
	endtask : rd
	task automatic wr(input logic [1:0] k, input logic [7:0] a,
		input logic [7:0] d, input logic e);
		logic [31:0] r;
		logic g;
		wb(1'b1, 8'h08, {14'h0, k, a, d}, r, g);
		chk({31'h0, g}, {31'h0, e});
		chk({14'h0, req}, {14'h0, k, a, d});
	endtask : wr
	task automatic flush();
		int n;
		n = 0;
		i_bus.start();
		i_bus.sendByte(8'hA0);
		i_bus.stop();
		chk({30'h0, active, busy}, 32'h3);
		while (busy !== 1'b0 && n < 200)
		begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, active}, 32'h0);
	endtask : flush
	task automatic setLock(input logic [1:0] st);
		wr(2'h3, 8'hFF, 8'h02, 1'b1);
		wr(2'h3, 8'hFF, 8'h06, 1'b1);
		wr(2'h3, 8'hFF, {3'h0, st, 3'h2}, 1'b1);
		flush();
	endtask : setLock
	task automatic tEnable();
		logic [31:0] r;
		rd(8'h04, r);
		chk(r, 32'h0);
		rd(8'h0C, r);
		chk(r, 32'h50);
		rd(8'h20, r);
		chk(r, 32'h0);
		wr(2'h2, 8'h00, 8'hAA, 1'b0);
		wr(2'h0, 8'h00, 8'h01, 1'b0);
		wr(2'h3, 8'hFF, 8'h02, 1'b1);
		wr(2'h0, 8'h00, 8'h01, 1'b1);
		wr(2'h2, 8'h10, 8'h55, 1'b1);
		flush();
	endtask : tEnable
	task automatic tLocks();
		logic [31:0] r;
		logic [7:0] a;
		logic e;
		for (int st = 1; st < 4; st++)
		begin
			setLock(st[1:0]);
			rd(8'h04, r);
			chk({30'h0, r[4:3]}, st);
			wr(2'h3, 8'hFF, 8'h06, 1'b1);
			wr(2'h0, 8'h00, 8'h01, 1'b0);
			wr(2'h1, 8'h00, 8'h01, 1'b0);
			for (int i = 0; i < 4; i++)
			begin
				a = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : (i == 2) ? 8'hBF : 8'hC0;
				e = (st == 1) ? (a < 8'hC0) : (st == 2) ? (a < 8'h80) : 1'b0;
				wr(2'h2, a, 8'h3C, e);
				if (e)
					flush();
			end
			rd(8'h04, r);
			chk({31'h0, r[2]}, 32'h0);
		end
		setLock(2'h0);
	endtask : tLocks
	task automatic tWp();
		logic [31:0] r;
		wp <= 1'b1;
		repeat (20) @(posedge clock);
		wr(2'h0, 8'h00, 8'h07, 1'b1);
		wr(2'h1, 8'h00, 8'h07, 1'b0);
		wr(2'h2, 8'h00, 8'h07, 1'b0);
		rd(8'h00, r);
		chk(r, 32'h22);
		wr(2'h3, 8'hFF, 8'h06, 1'b1);
		wr(2'h3, 8'hFF, 8'h0A, 1'b1);
		rd(8'h04, r);
		chk({30'h0, r[4:3]}, 32'h0);
		wp <= 1'b0;
		repeat (20) @(posedge clock);
	endtask : tWp
	task automatic tStandby();
		logic seen;
		int n;
		seen = 1'b0;
		n = 0;
		// A passed glitch would be a START and STOP, so watch every cycle.
		fork
			i_bus.glitch();
			repeat (10)
			begin
				@(posedge clock);
				seen = seen | active;
			end
		join
		chk({31'h0, seen}, 32'h0);
		i_bus.start();
		chk({31'h0, active}, 32'h1);
		i_bus.sendByte(8'hA2);
		chk({31'h0, active}, 32'h0);
		i_bus.stop();
		i_bus.start();
		i_bus.sendByte(8'hA1);
		chk({31'h0, active}, 32'h1);
		i_bus.setSda(1'b0);
		i_bus.setScl(1'b1);
		// Filter latency of sync plus window, one cycle to see the STOP.
		fork
			i_bus.setSda(1'b1);
			do
			begin
				@(posedge clock);
				n++;
			end
			while (active !== 1'b0 && n < 20);
		join
		chk(n, 32'(wpg_pkg::STANDBY_CYC + wpg_pkg::GLITCH_CYC + 5));
		chk({31'h0, active}, 32'h0);
	endtask : tStandby
	task automatic giveVerdict();
		if (badCount == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : giveVerdict
	initial
	begin
		#2000000;
		badCount++;
		giveVerdict();
	end
	initial
	begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		tEnable();
		tLocks();
		tWp();
		tStandby();
		giveVerdict();
	end
endmodule : tb_top
`default_nettype wire

/* wpg_bus_master.sv */
// Two-wire bus master model driving the guard's serial pins.
// Assumes pull-ups on both lines, so a released line reads high.
`timescale 1ns/1ns
`default_nettype none
module wpg_bus_master
#(
	parameter int HALF = 10
)
(
	// Clock
	input	wire logic	clock,
	// Bus lines
	output	var logic	scl,
	output	var logic	sda
);
	initial
	begin
		scl <= 1'b1;
		sda <= 1'b1;
	end
	task automatic setScl(input logic v);
		scl <= v;
		repeat (HALF) @(posedge clock);
	endtask : setScl
	task automatic setSda(input logic v);
		sda <= v;
		repeat (HALF) @(posedge clock);
	endtask : setSda
	task automatic start();
		setSda(1'b0);
		setScl(1'b0);
	endtask : start
	task automatic stop();
		setSda(1'b0);
		setScl(1'b1);
		setSda(1'b1);
	endtask : stop
	// Data only moves while the clock line is low, so no false frame edge.
	task automatic sendByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			setSda(b[i]);
			setScl(1'b1);
			setScl(1'b0);
		end
		setSda(1'b1);
		setScl(1'b1);
		setScl(1'b0);
	endtask : sendByte
	task automatic glitch();
		sda <= 1'b0;
		@(posedge clock);
		setSda(1'b1);
	endtask : glitch
endmodule : wpg_bus_master
`default_nettype wire

/* wpg_guard_chk.sv */
// Port checker for the guard: bus handshake, grants, write cycle.
// Assumes one clock domain with the synchronous reset srst.
`timescale 1ns/1ns
`default_nettype none
module wpg_guard_chk
#(
	parameter int NV_WRITE_CYCLES = 50
)
(
	// Clock and reset
	input	wire logic		clock,
	input	wire logic		srst,
	// Register bus
	input	wire logic		cyc_i,
	input	wire logic		stb_i,
	input	wire logic		we_i,
	input	wire logic [7:0]	adr_i,
	input	wire logic [3:0]	sel_i,
	input	wire logic [31:0]	dat_i,
	input	wire logic [31:0]	dat_o,
	input	wire logic		ack_o,
	// Pins
	input	wire logic		sclPin,
	input	wire logic		sdaPin,
	input	wire logic		wpPin,
	// Results
	input	wire logic		wrGrant,
	input	wire logic [17:0]	wrReq,
	input	wire logic		deviceActive,
	input	wire logic		nvBusy
);
	logic [31:0]	busyCnt_q;
	logic [31:0]	busyCnt_d;
	default clocking @(posedge clock);
	endclocking
	default disable iff (srst);
	always_comb
	begin
		busyCnt_d = nvBusy ? busyCnt_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge clock)
	begin
		if (srst)
			busyCnt_q <= 32'h0;
		else
			busyCnt_q <= busyCnt_d;
	end
	property p_ack_next;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
	// Read data is registered only when a request is taken.
	property p_dat_hold;
		$changed(dat_o) |-> ack_o;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("data moved");
	property p_grant_cause;
		wrGrant |-> ack_o
			&& $past(we_i && adr_i == wpg_pkg::REG_REQUEST && sel_i[0]);
	endproperty
	a_grant_cause: assert property (p_grant_cause) else $error("stray grant");
	property p_busy_act;
		nvBusy |-> deviceActive;
	endproperty
	a_busy_act: assert property (p_busy_act) else $error("idle in cycle");
	property p_busy_end;
		$fell(nvBusy) |-> !deviceActive;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("no standby");
	property p_busy_len;
		$fell(nvBusy) |-> busyCnt_q >= NV_WRITE_CYCLES
			&& busyCnt_q <= NV_WRITE_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("cycle length");
	property p_wp_nv;
		wrGrant && $past(wpPin, 12) && $past(wpPin, 3) |->
			wrReq[17:16] == 2'h0 || wrReq[17:16] == 2'h3;
	endproperty
	a_wp_nv: assert property (p_wp_nv) else $error("nv write with wp");
endmodule : wpg_guard_chk
bind wpg_write_permission_guard wpg_guard_chk
	#(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_chk
	(.clock(clock), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .sclPin(sclPin), .sdaPin(sdaPin), .wpPin(wpPin),
	.wrGrant(wrGrant), .wrReq(wrReq), .deviceActive(deviceActive),
	.nvBusy(nvBusy));
`default_nettype wire

/* wpg_input_filter.sv */
// Pin synchroniser with glitch suppression for one device pin input (scl, sda or wp).
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module wpg_input_filter
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// Pin and cleaned level
	input  wire logic pinIn,
	output var  logic level
);
	logic                meta_q;
	logic                sync_q;
	logic                level_q;
	logic                level_d;
	logic [3:0]          stable_q;
	logic [3:0]          stable_d;

	// A new level is taken only after it has been seen for more samples than
	// a glitch can span, so a pulse shorter than the window never passes.
	always_comb
	begin
		level_d  = level_q;
		stable_d = 4'h0;
		if (sync_q != level_q)
		begin
			stable_d = stable_q + 4'h1;
			if (stable_q >= 4'(wpg_pkg::GLITCH_CYC))
			begin
				level_d  = sync_q;
				stable_d = 4'h0;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			meta_q   <= 1'b1;
			sync_q   <= 1'b1;
			level_q  <= 1'b1;
			stable_q <= 4'h0;
		end
		else
		begin
			meta_q   <= pinIn;
			sync_q   <= meta_q;
			level_q  <= level_d;
			stable_q <= stable_d;
		end
	end

	assign level = level_q;
endmodule : wpg_input_filter
`default_nettype wire

/* wpg_pkg.sv */
// Shared constants and types for the write permission guard.
// Assumes a single 20 MHz clock and a 32-bit classic Wishbone register port.
package wpg_pkg;

	// Timing, each figure kept in its own unit.
	localparam int CLK_HZ           = 20_000_000;
	localparam int CLK_PER_US       = CLK_HZ / 1_000_000;
	localparam int NV_WRITE_TIME_US = 5000;
	localparam int NV_WRITE_MAX_US  = 10000;
	localparam int NV_WRITE_CYC     = NV_WRITE_TIME_US * CLK_PER_US;
	localparam int STANDBY_DELAY_NS = 200;
	localparam int STANDBY_CYC      = STANDBY_DELAY_NS * CLK_PER_US / 1000;
	localparam int GLITCH_NS        = 50;
	localparam int GLITCH_CYC       = (GLITCH_NS * CLK_PER_US + 999) / 1000;
	localparam int TIMER_W          = 17;

	// Serial bus framing.
	localparam logic [3:0] ADDR_BYTE_EDGES = 4'h8;
	localparam logic [3:0] ADDR_ACK_EDGE   = 4'h9;
	localparam logic [6:0] DEVSEL_RESET    = 7'h50;

	// Register byte offsets.
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_CONTROL_STATUS_REG = 8'h04;
	localparam logic [7:0] REG_REQUEST = 8'h08;
	localparam logic [7:0] REG_DEVSEL  = 8'h0C;

	// Control and status register bit positions.
	localparam int CS_WEL  = 1;
	localparam int CS_REG_WRITE_ENABLE_LATCH = 2;
	localparam int CS_BL0  = 3;
	localparam int CS_BL1  = 4;

	// Status register bit positions.
	localparam int SB_LAST_OK  = 0;
	localparam int SB_LAST_REF = 1;
	localparam int SB_ACTIVE   = 2;
	localparam int SB_NV_BUSY  = 3;
	localparam int SB_NV_PEND  = 4;
	localparam int SB_WP       = 5;

	// Lock partitions.
	localparam logic [1:0] LOCK_NONE    = 2'h0;
	localparam logic [1:0] LOCK_QUARTER = 2'h1;
	localparam logic [1:0] LOCK_HALF    = 2'h2;
	localparam logic [7:0] BASE_QUARTER = 8'hC0;
	localparam logic [7:0] BASE_HALF    = 8'h80;

	typedef enum logic [1:0] {
		KIND_POT_VOL = 2'b00,
		KIND_POT_NV  = 2'b01,
		KIND_ARRAY   = 2'b10,
		KIND_CONTROL_STATUS_REG = 2'b11
	} wpg_kind_type;

	typedef struct packed {
		wpg_kind_type kind;
		logic [7:0]   addr;
		logic [7:0]   data;
	} wpg_req_type;

	typedef enum logic [1:0] {
		ST_STANDBY  = 2'b00,
		ST_ACTIVE   = 2'b01,
		ST_STOPWAIT = 2'b10,
		ST_NVWRITE  = 2'b11
	} wpg_state_type;

	function automatic logic inLockedRegion(input logic [1:0] lockSel,
		input logic [7:0] addr);
		logic hit;
		hit = 1'b1;
		unique case (lockSel)
			LOCK_NONE:    hit = 1'b0;
			LOCK_QUARTER: hit = (addr >= BASE_QUARTER);
			LOCK_HALF:    hit = (addr >= BASE_HALF);
			default:      hit = 1'b1;
		endcase
		return hit;
	endfunction : inLockedRegion

endpackage : wpg_pkg

/* wpg_write_permission_guard.sv */
// Write permission and activity state logic for a two-wire bus device.
// Assumes Wishbone classic registers on clock, and raw scl, sda and wp pins.
// What this block does
// - WP high: only volatile writes pass
// - WP low, locked: no pot writes; quarter or half lock leaves partial array, both lock bits lock whole array
// - START activates; bad select standby at edge 9
// - Plain STOP: standby 200 ns later
// - Launching STOP: active through whole write cycle
// - Write cycle lasts 5 ms, at most 10
// - Inputs ignore pulses under 50 ns
// - Lock pair selects protected array partition
// - Every pot and array write needs write enable latch first
// - Locked array write aborted, nothing stored
// - Locked array attempt clears register enable latch
`timescale 1ns/1ns
`default_nettype none
module wpg_write_permission_guard
#(
	parameter int NV_WRITE_CYCLES = wpg_pkg::NV_WRITE_CYC
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output var  logic [31:0] dat_o,
	output var  logic        ack_o,
	// Device pins
	input  wire logic        sclPin,
	input  wire logic        sdaPin,
	input  wire logic        wpPin,
	// Granted write towards storage
	output var  logic        wrGrant,
	output var  logic [17:0] wrReq,
	// Device state
	output var  logic        deviceActive,
	output var  logic        nvBusy
);
	logic [2:0]            pinClean;
	logic                  sclF;
	logic                  sdaF;
	logic                  wpF;
	logic                  sclPrev_q;
	logic                  sdaPrev_q;
	logic                  busStart;
	logic                  busStop;
	logic                  sclRise;
	logic [3:0]            bitCnt_q;
	logic [3:0]            bitCnt_d;
	logic [7:0]            addrByte_q;
	logic [7:0]            addrByte_d;
	logic                  selMatch;
	wpg_pkg::wpg_state_type state_q;
	wpg_pkg::wpg_state_type state_d;
	logic [wpg_pkg::TIMER_W-1:0] timer_q;
	logic [wpg_pkg::TIMER_W-1:0] timer_d;
	logic                  ack_q;
	logic                  ack_d;
	logic [31:0]           rdata_q;
	logic [31:0]           rdata_d;
	logic [6:0]            devSel_q;
	logic [6:0]            devSel_d;
	wpg_pkg::wpg_req_type  req_q;
	wpg_pkg::wpg_req_type  req_d;
	logic                  reqFire;
	logic                  wel_q;
	logic                  wel_d;
	logic                  reg_write_enable_latch_q;
	logic                  reg_write_enable_latch_d;
	logic [1:0]            lock_q;
	logic [1:0]            lock_d;
	logic                  nvPend_q;
	logic                  nvPend_d;
	logic                  grant_q;
	logic                  grant_d;
	logic                  lastOk_q;
	logic                  lastOk_d;
	logic                  lastRef_q;
	logic                  lastRef_d;
	logic [7:0]            constatImage;
	logic                  busAccess;

	for (genvar i = 0; i < 3; i++)
	begin : g_pin
		wpg_input_filter u_filter
		(
			.clock (clock),
			.srst  (srst),
			.pinIn ((i == 0) ? sclPin : ((i == 1) ? sdaPin : wpPin)),
			.level (pinClean[i])
		);
	end

	assign sclF     = pinClean[0];
	assign sdaF     = pinClean[1];
	assign wpF      = pinClean[2];
	assign busStart = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
	assign busStop  = sclF & sclPrev_q & ~sdaPrev_q & sdaF;
	assign sclRise  = sclF & ~sclPrev_q;
	assign selMatch = (addrByte_q[7:1] == devSel_q);
	assign busAccess = cyc_i & stb_i & ~ack_q;
	assign reqFire  = busAccess & we_i & sel_i[0]
		& (adr_i == wpg_pkg::REG_REQUEST);

	// Activity tracking and the self-timed write cycle.
	always_comb
	begin
		state_d    = state_q;
		timer_d    = timer_q;
		bitCnt_d   = bitCnt_q;
		addrByte_d = addrByte_q;
		if (sclRise && bitCnt_q < wpg_pkg::ADDR_ACK_EDGE)
		begin
			bitCnt_d = bitCnt_q + 4'h1;
			if (bitCnt_q < wpg_pkg::ADDR_BYTE_EDGES)
			begin
				addrByte_d = {addrByte_q[6:0], sdaF};
			end
		end
		unique case (state_q)
			wpg_pkg::ST_STANDBY, wpg_pkg::ST_STOPWAIT, wpg_pkg::ST_ACTIVE:
			begin
				if (state_q == wpg_pkg::ST_STOPWAIT)
				begin
					if (timer_q == '0)
					begin
						state_d = wpg_pkg::ST_STANDBY;
					end
					else
					begin
						timer_d = timer_q - 1'b1;
					end
				end
				if (state_q == wpg_pkg::ST_ACTIVE && sclRise && !selMatch
					&& bitCnt_q == wpg_pkg::ADDR_BYTE_EDGES)
				begin
					state_d = wpg_pkg::ST_STANDBY;
				end
				if (state_q == wpg_pkg::ST_ACTIVE && busStop)
				begin
					if (nvPend_q)
					begin
						state_d = wpg_pkg::ST_NVWRITE;
						timer_d = wpg_pkg::TIMER_W'(NV_WRITE_CYCLES - 1);
					end
					else
					begin
						state_d = wpg_pkg::ST_STOPWAIT;
						timer_d = wpg_pkg::TIMER_W'(wpg_pkg::STANDBY_CYC - 1);
					end
				end
				if (busStart)
				begin
					state_d  = wpg_pkg::ST_ACTIVE;
					bitCnt_d = 4'h0;
				end
			end
			wpg_pkg::ST_NVWRITE:
			begin
				if (timer_q == '0)
				begin
					state_d = wpg_pkg::ST_STANDBY;
				end
				else
				begin
					timer_d = timer_q - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_q    <= wpg_pkg::ST_STANDBY;
			timer_q    <= '0;
			bitCnt_q   <= 4'h0;
			addrByte_q <= 8'h00;
			sclPrev_q  <= 1'b1;
			sdaPrev_q  <= 1'b1;
		end
		else
		begin
			state_q    <= state_d;
			timer_q    <= timer_d;
			bitCnt_q   <= bitCnt_d;
			addrByte_q <= addrByte_d;
			sclPrev_q  <= sclF;
			sdaPrev_q  <= sdaF;
		end
	end

	// Permission decisions for each write request.
	always_comb
	begin
		req_d     = req_q;
		wel_d     = wel_q;
		reg_write_enable_latch_d    = reg_write_enable_latch_q;
		lock_d    = lock_q;
		nvPend_d  = nvPend_q;
		grant_d   = 1'b0;
		lastOk_d  = lastOk_q;
		lastRef_d = lastRef_q;
		if (state_q == wpg_pkg::ST_NVWRITE && state_d != wpg_pkg::ST_NVWRITE)
		begin
			nvPend_d = 1'b0;
		end
		if (busAccess && we_i && adr_i == wpg_pkg::REG_REQUEST)
		begin
			if (sel_i[0])
			begin
				req_d.data = dat_i[7:0];
			end
			if (sel_i[1])
			begin
				req_d.addr = dat_i[15:8];
			end
			if (sel_i[2])
			begin
				req_d.kind = wpg_pkg::wpg_kind_type'(dat_i[17:16]);
			end
		end
		if (reqFire)
		begin
			grant_d = 1'b0;
			// A request during the write cycle is refused, as the array is
			// unavailable until the cycle ends.
			if (state_q != wpg_pkg::ST_NVWRITE)
			begin
				unique case (req_d.kind)
					wpg_pkg::KIND_POT_VOL:
						grant_d = wel_q && lock_q == wpg_pkg::LOCK_NONE;
					wpg_pkg::KIND_POT_NV:
						grant_d = wel_q && lock_q == wpg_pkg::LOCK_NONE
							&& !wpF;
					wpg_pkg::KIND_ARRAY:
					begin
						grant_d = wel_q && !wpF
							&& !wpg_pkg::inLockedRegion(lock_q, req_d.addr);
						if (wpg_pkg::inLockedRegion(lock_q, req_d.addr))
						begin
							reg_write_enable_latch_d = 1'b0;
						end
					end
					wpg_pkg::KIND_CONTROL_STATUS_REG:
					begin
						grant_d = 1'b1;
						wel_d   = req_d.data[wpg_pkg::CS_WEL];
						if (req_d.data[wpg_pkg::CS_REG_WRITE_ENABLE_LATCH])
						begin
							reg_write_enable_latch_d  = wel_q;
							grant_d = wel_q;
						end
						else if (wel_q && reg_write_enable_latch_q)
						begin
							// Nonvolatile lock bits need WP low
							if (!wpF)
							begin
								lock_d   = {req_d.data[wpg_pkg::CS_BL1],
									req_d.data[wpg_pkg::CS_BL0]};
								nvPend_d = 1'b1;
								reg_write_enable_latch_d   = 1'b0;
							end
						end
					end
				endcase
				if (grant_d && (req_d.kind == wpg_pkg::KIND_POT_NV
					|| req_d.kind == wpg_pkg::KIND_ARRAY))
				begin
					nvPend_d = 1'b1;
				end
			end
			lastOk_d  = grant_d;
			lastRef_d = !grant_d;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			req_q     <= '0;
			wel_q     <= 1'b0;
			reg_write_enable_latch_q    <= 1'b0;
			lock_q    <= wpg_pkg::LOCK_NONE;
			nvPend_q  <= 1'b0;
			grant_q   <= 1'b0;
			lastOk_q  <= 1'b0;
			lastRef_q <= 1'b0;
		end
		else
		begin
			req_q     <= req_d;
			wel_q     <= wel_d;
			reg_write_enable_latch_q    <= reg_write_enable_latch_d;
			lock_q    <= lock_d;
			nvPend_q  <= nvPend_d;
			grant_q   <= grant_d;
			lastOk_q  <= lastOk_d;
			lastRef_q <= lastRef_d;
		end
	end

	// Register port: one wait state, unmapped reads return zero.
	always_comb
	begin
		constatImage                   = 8'h00;
		constatImage[wpg_pkg::CS_WEL]  = wel_q;
		constatImage[wpg_pkg::CS_REG_WRITE_ENABLE_LATCH] = reg_write_enable_latch_q;
		constatImage[wpg_pkg::CS_BL0]  = lock_q[0];
		constatImage[wpg_pkg::CS_BL1]  = lock_q[1];
		ack_d    = busAccess;
		devSel_d = devSel_q;
		rdata_d  = rdata_q;
		if (busAccess && we_i && sel_i[0] && adr_i == wpg_pkg::REG_DEVSEL)
		begin
			devSel_d = dat_i[6:0];
		end
		if (busAccess)
		begin
			rdata_d = 32'h0000_0000;
			unique case (adr_i)
				wpg_pkg::REG_STATUS:
				begin
					rdata_d[wpg_pkg::SB_LAST_OK]  = lastOk_q;
					rdata_d[wpg_pkg::SB_LAST_REF] = lastRef_q;
					rdata_d[wpg_pkg::SB_ACTIVE]   = deviceActive;
					rdata_d[wpg_pkg::SB_NV_BUSY]  = nvBusy;
					rdata_d[wpg_pkg::SB_NV_PEND]  = nvPend_q;
					rdata_d[wpg_pkg::SB_WP]       = wpF;
				end
				wpg_pkg::REG_CONTROL_STATUS_REG: rdata_d[7:0] = constatImage;
				wpg_pkg::REG_REQUEST: rdata_d[17:0] = req_q;
				wpg_pkg::REG_DEVSEL:  rdata_d[6:0] = devSel_q;
				default:              rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			ack_q    <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			devSel_q <= wpg_pkg::DEVSEL_RESET;
		end
		else
		begin
			ack_q    <= ack_d;
			rdata_q  <= rdata_d;
			devSel_q <= devSel_d;
		end
	end

	assign ack_o        = ack_q;
	assign dat_o        = rdata_q;
	assign wrGrant      = grant_q;
	assign wrReq        = req_q;
	assign deviceActive = (state_q != wpg_pkg::ST_STANDBY);
	assign nvBusy       = (state_q == wpg_pkg::ST_NVWRITE);
endmodule : wpg_write_permission_guard
`default_nettype wire
